// ### hdl/fbps_decode.sv
// Sector protection decoder for one density
`timescale 1ns/100ps
module fbps_decode
  import fbps_pkg::*;
#(
  parameter int SECTORS = 64
) (
  // Protection settings
  input wire logic low_end,
  input wire logic [2:0] level,
  // Query
  input wire logic [SECTOR_W-1:0] sector,
  output logic protected_hit
);
  logic [SECTOR_W:0] span;
  logic [SECTOR_W:0] total;

  // Region size doubles per level, saturating at the whole array
  assign total = (SECTOR_W+1)'(SECTORS);
  assign span = (level == 3'h0) ? '0 :
                ((SECTOR_W+1)'(1) << (level - 3'h1));

  always_comb begin
    if (level == 3'h0) begin
      protected_hit = 1'b0;
    end else if (span >= total) begin
      protected_hit = 1'b1;
    end else if (low_end) begin
      protected_hit = {1'b0, sector} < span;
    end else begin
      protected_hit = {1'b0, sector} >= (total - span);
    end
  end
endmodule

// ### hdl/fbps_pkg.sv
// Package of constants for the flash status and block protection block
package fbps_pkg;
  // Status bit positions
  localparam int STAT_RSVD_HI = 7;
  localparam int STAT_RSVD_LO = 6;
  localparam int STAT_LOW_END = 5;
  localparam int STAT_LVL_MSB = 4;
  localparam int STAT_LVL_LSB = 2;
  localparam int STAT_PERMIT = 1;
  localparam int STAT_BUSY = 0;
  localparam logic [7:0] STAT_RESET = 8'h00;
  // Operation codes on the serial link
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_PROGRAM = 8'h02;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_BULK_ERASE = 8'hC7;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'hD8;
  // Frame lengths in bytes
  localparam logic [8:0] LEN_SHORT_OP = 9'h001;
  localparam logic [8:0] LEN_STATUS_WR = 9'h002;
  localparam logic [8:0] LEN_SECTOR_OP = 9'h004;
  localparam logic [8:0] LEN_PROGRAM_MIN = 9'h005;
  // Sector address field of a 24-bit byte address (64 KB sectors)
  localparam int SECTOR_LSB = 16;
  localparam int SECTOR_W = 8;
  // Self-timed status write
  localparam int CLK_PERIOD_PS = 10000;
  localparam longint STATUS_WR_TYP_MS = 10;
  localparam longint STATUS_WR_MAX_MS = 15;
  localparam int STATUS_WR_CYCLES =
    int'((STATUS_WR_TYP_MS * 64'd1000000000) / CLK_PERIOD_PS);
  // Busy sequencer
  typedef enum logic [2:0] {
    FBPS_IDLE = 3'b001,
    FBPS_STATUS_WR = 3'b010,
    FBPS_ARRAY_OP = 3'b100
  } fbps_state_t;
endpackage

// ### hdl/fbps_top.sv
// Status register, serial status access and block protection gate
`timescale 1ns/100ps
module fbps_top
  import fbps_pkg::*;
#(
  parameter int SECTORS = 64,
  parameter int STATUS_WR_CYC = STATUS_WR_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  // Serial link pins
  input wire logic sclk_pin,
  input wire logic select_n_pin,
  input wire logic data_in_pin,
  output logic data_out,
  output logic data_out_oe_n,
  // Memory array side
  output logic array_program_req,
  output logic array_sector_erase_req,
  output logic array_bulk_erase_req,
  output logic [23:0] array_addr,
  output logic [7:0] array_data,
  input wire logic array_done,
  // Status view
  output logic [7:0] status_value
);
  logic [2:0] sclk_sync_reg;
  logic [2:0] sel_sync_reg;
  logic [1:0] din_sync_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic sel_start;
  logic sel_end;
  logic sel_active;
  logic [11:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] opcode_reg;
  logic [23:0] addr_reg;
  logic [7:0] wr_data_reg;
  logic [7:0] out_byte_reg;
  logic [2:0] out_idx_reg;
  logic low_end_reg;
  logic [2:0] level_reg;
  logic [3:0] pending_reg;
  logic permit_reg;
  fbps_state_t state_reg;
  fbps_state_t state_next;
  logic [31:0] timer_reg;
  logic byte_done;
  logic [8:0] byte_idx;
  logic [8:0] frame_bytes;
  logic aligned;
  logic target_prot;
  logic is_idle;
  logic do_enable;
  logic do_disable;
  logic do_status_wr;
  logic do_program;
  logic do_sector;
  logic do_bulk;
  logic cycle_end;
  logic reading;

  // Two-stage synchronisers plus one stage for edge finding
  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_sync_reg <= 3'h0;
      sel_sync_reg <= 3'h7;
      din_sync_reg <= 2'h0;
    end else if (clk_en) begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_pin};
      sel_sync_reg <= {sel_sync_reg[1:0], select_n_pin};
      din_sync_reg <= {din_sync_reg[0], data_in_pin};
    end
  end

  assign sel_active = ~sel_sync_reg[1];
  assign sel_start = sel_sync_reg[2] & ~sel_sync_reg[1];
  assign sel_end = ~sel_sync_reg[2] & sel_sync_reg[1];
  assign sclk_rise = sel_active & ~sclk_sync_reg[2] & sclk_sync_reg[1];
  assign sclk_fall = sel_active & sclk_sync_reg[2] & ~sclk_sync_reg[1];
  assign byte_done = sclk_rise & (bit_cnt_reg[2:0] == 3'h7);
  assign byte_idx = bit_cnt_reg[11:3];
  assign frame_bytes = bit_cnt_reg[11:3];
  assign aligned = bit_cnt_reg[2:0] == 3'h0;

  // Frame capture: opcode, three address bytes, then data
  always_ff @(posedge clk) begin
    if (rst) begin
      bit_cnt_reg <= 12'h000;
      shift_reg <= 8'h00;
      opcode_reg <= 8'h00;
      addr_reg <= 24'h000000;
      wr_data_reg <= 8'h00;
    end else if (clk_en) begin
      if (sel_start) begin
        bit_cnt_reg <= 12'h000;
        opcode_reg <= 8'h00;
      end else if (sclk_rise) begin
        shift_reg <= {shift_reg[6:0], din_sync_reg[1]};
        if (bit_cnt_reg != 12'hFFF) begin
          bit_cnt_reg <= bit_cnt_reg + 12'h001;
        end
        if (byte_done) begin
          case (byte_idx)
            9'h000: opcode_reg <= {shift_reg[6:0], din_sync_reg[1]};
            9'h001: begin
              addr_reg[23:16] <= {shift_reg[6:0], din_sync_reg[1]};
              wr_data_reg <= {shift_reg[6:0], din_sync_reg[1]};
            end
            9'h002: addr_reg[15:8] <= {shift_reg[6:0], din_sync_reg[1]};
            9'h003: addr_reg[7:0] <= {shift_reg[6:0], din_sync_reg[1]};
            default: wr_data_reg <= {shift_reg[6:0], din_sync_reg[1]};
          endcase
        end
      end
    end
  end

  fbps_decode #(
    .SECTORS(SECTORS)
  ) u_decode (
    .low_end(low_end_reg),
    .level(level_reg),
    .sector(addr_reg[SECTOR_LSB +: SECTOR_W]),
    .protected_hit(target_prot)
  );

  // Decisions taken when select rises on a byte boundary
  assign is_idle = state_reg == FBPS_IDLE;
  assign do_enable = sel_end & aligned & (opcode_reg == OP_WRITE_ENABLE)
                     & (frame_bytes == LEN_SHORT_OP);
  assign do_disable = sel_end & aligned & (opcode_reg == OP_WRITE_DISABLE)
                      & (frame_bytes == LEN_SHORT_OP);
  assign do_status_wr = sel_end & aligned & is_idle & permit_reg
                        & (opcode_reg == OP_WRITE_STATUS)
                        & (frame_bytes >= LEN_STATUS_WR);
  assign do_program = sel_end & aligned & is_idle & permit_reg
                      & (opcode_reg == OP_PROGRAM)
                      & (frame_bytes >= LEN_PROGRAM_MIN)
                      & ~target_prot;
  assign do_sector = sel_end & aligned & is_idle & permit_reg
                     & (opcode_reg == OP_SECTOR_ERASE)
                     & (frame_bytes == LEN_SECTOR_OP)
                     & ~target_prot;
  assign do_bulk = sel_end & aligned & is_idle & permit_reg
                   & (opcode_reg == OP_BULK_ERASE)
                   & (frame_bytes == LEN_SHORT_OP)
                   & (level_reg == 3'h0);

  // Busy sequencer for self-timed status write and array cycles
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      FBPS_IDLE: begin
        if (do_status_wr) begin
          state_next = FBPS_STATUS_WR;
        end else if (do_program | do_sector | do_bulk) begin
          state_next = FBPS_ARRAY_OP;
        end
      end
      FBPS_STATUS_WR: begin
        if (timer_reg == 32'(STATUS_WR_CYC - 1)) begin
          state_next = FBPS_IDLE;
        end
      end
      FBPS_ARRAY_OP: begin
        if (array_done) begin
          state_next = FBPS_IDLE;
        end
      end
      default: state_next = FBPS_IDLE;
    endcase
  end

  assign cycle_end = (state_reg != FBPS_IDLE) & (state_next == FBPS_IDLE);

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= FBPS_IDLE;
      timer_reg <= 32'h00000000;
    end else if (clk_en) begin
      state_reg <= state_next;
      if (state_reg == FBPS_STATUS_WR) begin
        timer_reg <= timer_reg + 32'h00000001;
      end else begin
        timer_reg <= 32'h00000000;
      end
    end
  end

  // Protection fields take the written value when the timed cycle ends
  always_ff @(posedge clk) begin
    if (rst) begin
      low_end_reg <= STAT_RESET[STAT_LOW_END];
      level_reg <= STAT_RESET[STAT_LVL_MSB:STAT_LVL_LSB];
      pending_reg <= 4'h0;
    end else if (clk_en) begin
      if (do_status_wr) begin
        pending_reg <= wr_data_reg[STAT_LOW_END:STAT_LVL_LSB];
      end
      if ((state_reg == FBPS_STATUS_WR) && cycle_end) begin
        low_end_reg <= pending_reg[3];
        level_reg <= pending_reg[2:0];
      end
    end
  end

  // Write-permit latch; a write enable beats the end-of-cycle clear
  always_ff @(posedge clk) begin
    if (rst) begin
      permit_reg <= STAT_RESET[STAT_PERMIT];
    end else if (clk_en) begin
      if (do_enable) begin
        permit_reg <= 1'b1;
      end else if (do_disable | cycle_end) begin
        permit_reg <= 1'b0;
      end
    end
  end

  // Array requests with the captured target
  always_ff @(posedge clk) begin
    if (rst) begin
      array_program_req <= 1'b0;
      array_sector_erase_req <= 1'b0;
      array_bulk_erase_req <= 1'b0;
      array_addr <= 24'h000000;
      array_data <= 8'h00;
    end else if (clk_en) begin
      array_program_req <= do_program;
      array_sector_erase_req <= do_sector;
      array_bulk_erase_req <= do_bulk;
      if (do_program | do_sector) begin
        array_addr <= addr_reg;
        array_data <= wr_data_reg;
      end
    end
  end

  // Reserved bits read as zero
  always_comb begin
    status_value = STAT_RESET;
    status_value[STAT_LOW_END] = low_end_reg;
    status_value[STAT_LVL_MSB:STAT_LVL_LSB] = level_reg;
    status_value[STAT_PERMIT] = permit_reg;
    status_value[STAT_BUSY] = state_reg != FBPS_IDLE;
  end

  // Status read: fresh snapshot each byte, repeated until select rises
  assign reading = sel_active & (opcode_reg == OP_READ_STATUS)
                   & (bit_cnt_reg >= 12'h008);

  always_ff @(posedge clk) begin
    if (rst) begin
      out_idx_reg <= 3'h0;
      out_byte_reg <= 8'h00;
      data_out <= 1'b0;
      data_out_oe_n <= 1'b1;
    end else if (clk_en) begin
      data_out_oe_n <= ~reading;
      if (~reading) begin
        out_idx_reg <= 3'h0;
      end else if (sclk_fall) begin
        out_idx_reg <= out_idx_reg + 3'h1;
        if (out_idx_reg == 3'h0) begin
          out_byte_reg <= {status_value[6:0], 1'b0};
          data_out <= status_value[7];
        end else begin
          out_byte_reg <= {out_byte_reg[6:0], 1'b0};
          data_out <= out_byte_reg[7];
        end
      end
    end
  end
endmodule

// ### sim/fbps_asserts.sv
// Checker of the status and protection gate ports
`timescale 1ns/100ps
module fbps_asserts
  import fbps_pkg::*;
#(
  parameter int SECTORS = 64,
  parameter int STATUS_WR_CYC = STATUS_WR_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  // Observed ports
  input wire logic select_n_pin,
  input wire logic data_out_oe_n,
  input wire logic array_program_req,
  input wire logic array_sector_erase_req,
  input wire logic array_bulk_erase_req,
  input wire logic [23:0] array_addr,
  input wire logic [7:0] status_value
);
  `include "fbps_exp.svh"
  logic any_req;
  logic arr_seen;
  int wr_cnt;
  assign any_req = array_program_req | array_sector_erase_req |
    array_bulk_erase_req;
  // Busy stretch length and whether an array request opened it
  always_ff @(posedge clk) begin
    if (rst) begin
      arr_seen <= 1'b0;
      wr_cnt <= 0;
    end else if (clk_en) begin
      if (!status_value[0]) begin
        arr_seen <= 1'b0;
        wr_cnt <= 0;
      end else begin
        arr_seen <= arr_seen | any_req;
        wr_cnt <= wr_cnt + 1;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence desel_s;
    select_n_pin [*8];
  endsequence
  sequence req_s;
    any_req;
  endsequence
  a_reserved_zero: assert property (status_value[7:6] == 2'b00)
    else $error("reserved status bits set");
  a_reset_clears: assert property (disable iff (1'b0)
    rst && clk_en |=> status_value == STAT_RESET)
    else $error("status not cleared by reset");
  a_req_busy: assert property (req_s |-> ##[0:2] status_value[0])
    else $error("busy not raised by array request");
  a_req_permit: assert property (req_s |-> $past(status_value[1]))
    else $error("array request without permit");
  a_req_idle: assert property (req_s |-> !$past(status_value[0]))
    else $error("array request while busy");
  a_bulk_open: assert property (array_bulk_erase_req |->
    status_value[4:2] == 3'b000)
    else $error("bulk erase with protection set");
  a_sector_gate: assert property (
    (array_program_req || array_sector_erase_req) |->
    !prot_exp(SECTORS, status_value[4:2], status_value[5],
    int'(array_addr[23:16])))
    else $error("request to protected sector");
  a_oe_idle: assert property (desel_s |-> data_out_oe_n)
    else $error("data output enabled while deselected");
  a_level_hold: assert property (
    !status_value[0] && !$past(status_value[0]) |->
    $stable(status_value[5:2]))
    else $error("protection changed outside a write cycle");
  a_wr_length: assert property (
    $fell(status_value[0]) && !$past(any_req) && !$past(arr_seen) |->
    $past(wr_cnt) == STATUS_WR_CYC - 1)
    else $error("self-timed status write has wrong length");
endmodule

bind fbps_top fbps_asserts #(
  .SECTORS(SECTORS),
  .STATUS_WR_CYC(STATUS_WR_CYC)
) u_chk (
  .clk(clk),
  .rst(rst),
  .clk_en(clk_en),
  .select_n_pin(select_n_pin),
  .data_out_oe_n(data_out_oe_n),
  .array_program_req(array_program_req),
  .array_sector_erase_req(array_sector_erase_req),
  .array_bulk_erase_req(array_bulk_erase_req),
  .array_addr(array_addr),
  .status_value(status_value)
);

// ### sim/fbps_exp.svh
// Expected protection of one sector for a density and setting
function automatic logic prot_exp(input int n, input logic [2:0] lvl,
  input logic lo, input int s);
  int sp;
  sp = (lvl == 3'h0) ? 0 : (1 << (lvl - 1));
  if (sp > n || lvl == 3'h7) sp = n;
  return lo ? (s < sp) : (s >= n - sp);
endfunction

// ### sim/fbps_host.sv
// Host side of the serial link, bits sent MSB first
`timescale 1ns/100ps
module fbps_host (
  // Serial link
  output logic sclk,
  output logic sel_n,
  output logic din,
  input wire logic dout
);
  initial begin
    sclk = 1'b0;
    sel_n = 1'b1;
    din = 1'b0;
  end
  // Frame of n whole bytes from the top of v; rd keeps the last 8 bits
  task automatic xfer(input logic [39:0] v, input int n,
    output logic [7:0] rd);
    // Start off the system clock edge
    #2;
    sel_n = 1'b0;
    #100;
    for (int i = 0; i < n * 8; i++) begin
      din = v[39 - i];
      #62.5 sclk = 1'b1;
      rd = {rd[6:0], dout};
      #62.5 sclk = 1'b0;
    end
    #40 sel_n = 1'b1;
    din = ~din;
    #60;
  endtask
endmodule

// ### sim/tb_top.sv
// Bench for the status register and protection gate
`timescale 1ns/100ps
module tb_top;
  import fbps_pkg::*;
  `include "fbps_exp.svh"
  localparam int NS = 64;
  logic clk = 0, rst = 1, clk_en = 1, done = 0, hold = 0, lo;
  logic sclk, sel_n, din, dout, dbus, oe_n, p_req, s_req, b_req;
  logic [2:0] lv;
  logic [23:0] addr;
  logic [7:0] adat, stat, rd;
  int fails = 0, samples_checked = 0, reqs = 0, wt = 0, sp;
  always #5 clk = ~clk;
  fbps_top #(.SECTORS(NS), .STATUS_WR_CYC(400)) uut (.clk(clk),
    .rst(rst), .clk_en(clk_en), .sclk_pin(sclk), .select_n_pin(sel_n),
    .data_in_pin(din), .data_out(dout), .data_out_oe_n(oe_n),
    .array_program_req(p_req), .array_sector_erase_req(s_req),
    .array_bulk_erase_req(b_req), .array_addr(addr), .array_data(adat),
    .array_done(done), .status_value(stat));
  // Undriven data line reads inverted
  assign dbus = oe_n ? ~dout : dout;
  fbps_host u_host (.sclk(sclk), .sel_n(sel_n), .din(din), .dout(dbus));
  // Array finishes six cycles after a request unless held
  always @(posedge clk) begin
    done <= (wt == 1) && !hold;
    if (p_req | s_req | b_req) begin
      reqs <= reqs + 1;
      wt <= 6;
    end else if (wt > 0 && !hold) begin
      wt <= wt - 1;
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic op(input logic [39:0] v, input int n);
    u_host.xfer(v, n, rd);
    repeat (8) @(posedge clk);
  endtask
  task automatic rdst(input logic [7:0] exp);
    op({OP_READ_STATUS, 32'h0}, 2);
    check(rd, exp);
  endtask
  task automatic idle_wait();
    for (int i = 0; i < 600 && stat[0] !== 1'b0; i++) @(posedge clk);
    check({7'h0, stat[0]}, 8'h00);
  endtask
  task automatic wrst(input logic [7:0] v);
    idle_wait();
    op({OP_WRITE_ENABLE, 32'h0}, 1);
    op({OP_WRITE_STATUS, v, 24'h0}, 2);
    check({7'h0, stat[0]}, 8'h01);
    idle_wait();
  endtask
  // Permitted array operation; exp says whether it is taken
  task automatic arr(input logic [39:0] v, input int n, input logic exp);
    int r0;
    r0 = reqs;
    op({OP_WRITE_ENABLE, 32'h0}, 1);
    op(v, n);
    repeat (12) @(posedge clk);
    check(8'(reqs - r0), {7'h0, exp});
  endtask
  task automatic sec(input int s);
    s = (s < 0) ? 0 : (s >= NS) ? NS - 1 : s;
    arr({OP_SECTOR_ERASE, 8'(s), 24'h0}, 4, !prot_exp(NS, lv, lo, s));
  endtask
  initial begin
    #600000;
    fails++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    check(stat, STAT_RESET);
    rdst(8'h00);
    op({OP_WRITE_STATUS, 8'h1C, 24'h0}, 2);
    repeat (500) @(posedge clk);
    check(stat, 8'h00);
    op({OP_WRITE_ENABLE, 32'h0}, 1);
    rdst(8'h02);
    op({OP_WRITE_STATUS, 8'h3F, 24'h0}, 2);
    check(stat, 8'h03);
    clk_en <= 1'b0;
    repeat (500) @(posedge clk);
    check(stat, 8'h03);
    clk_en <= 1'b1;
    rdst(8'h03);
    wrst(8'h3C);
    check(stat, 8'h3C);
    arr({OP_BULK_ERASE, 32'h0}, 1, 1'b0);
    for (int k = 0; k < 16; k++) begin
      lv = k[2:0];
      lo = k[3];
      wrst(8'(k << 2));
      check(stat, 8'(k << 2));
      sp = (lv == 3'h0) ? 0 : (1 << (lv - 1));
      if (sp > NS || lv == 3'h7) sp = NS;
      sec(lo ? sp - 1 : NS - sp);
      sec(lo ? sp : NS - 1 - sp);
      arr({OP_BULK_ERASE, 32'h0}, 1, lv == 3'h0);
    end
    wrst(8'h00);
    lv = 3'h0;
    hold <= 1'b1;
    arr({OP_PROGRAM, 24'h2A1234, 8'h5C}, 5, 1'b1);
    check(addr[23:16], 8'h2A);
    check(adat, 8'h5C);
    rdst(8'h03);
    arr({OP_SECTOR_ERASE, 8'h03, 24'h0}, 4, 1'b0);
    hold <= 1'b0;
    repeat (12) @(posedge clk);
    check(stat, 8'h00);
    print_verdict();
  end
endmodule
